// ---- supervisor_consts.vh ----
// Constants for the supervision and restart controller
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_RELAY_CTRL 8'h00
`define ADDR_STATUS     8'h04
`define ADDR_DEFECT     8'h08
`define ADDR_SAVE       8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SAVE_EF_ZERO_BIT 0
`define SAVE_EXT_N_BIT   1
`define SAVE_NPS_BIT     2
`define SAVE_GO_BIT      8
`define RELAY_REQ_RST    4'h0

// ----------------------------------------
// Defect and display codes
// ----------------------------------------
`define DEF_NONE        10'h000
`define DEF_RESTART     10'h063
`define DEF_NONBLOCK    10'h050
`define DEF_EPROM       10'h032
`define DEF_ADC         10'h03c
`define DEF_NEG_SUPPLY  10'h03d
`define DEF_BASE_LINK   10'h00b
`define DEF_EXT_LINK    10'h01f
`define MODE_SAVE_ERROR 10'h3e7

// ----------------------------------------
// Converter channel windows
// ----------------------------------------
`define NEG_LO 8'h40
`define NEG_HI 8'hc0
`define ADC_LO 8'h70
`define ADC_HI 8'h90

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ    25000
`define LOCKOUT_MS 10000
`define RESTART_MS 5000
`define CHECK_MS   1

`endif

// ---- supervisor_restart_blocking.v ----
// Supervision, restart lockout and blocking controller with APB registers
//
// Our own choices: register access over APB and the register offsets.
`include "supervisor_consts.vh"

module supervisor_restart_blocking #(
	parameter CNT_W           = 28,
	parameter LOCKOUT_CYCLES  = `LOCKOUT_MS * `CLK_KHZ,
	parameter RESTART_CYCLES  = `RESTART_MS * `CLK_KHZ,
	parameter CHECK_CYCLES    = `CHECK_MS * `CLK_KHZ
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        logic_supply_low,
	input  wire        relay_supply_low,
	input  wire        proc_disturbance,
	input  wire        block_in,
	input  wire        block_scope_link,
	input  wire [3:0]  per_relay_block_switches,
	input  wire [1:0]  base_range_link,
	input  wire        ext_neutral_range_link,
	input  wire        checksum_ok,
	input  wire        selftest_ok,
	input  wire [7:0]  neg_supply_channel,
	input  wire [7:0]  adc_check_channel,
	input  wire        reset_key,
	input  wire        other_key,
	output reg  [3:0]  relay_out_r,
	output reg         standby_relay_r,
	output reg         standby_led_r,
	output reg         display_on_r,
	output reg         display_flash_r,
	output reg  [9:0]  mode_code_r,
	output reg         restart_ind_r,
	output reg         proc_block_r,
	output reg         hw_reset_r,
	output reg         nv_save_r,
	output reg         settings_copy_r,
	output reg         settings_save_r,
	output reg         key_accept_r
);

	localparam ST_RUN     = 2'h0;
	localparam ST_FAIL    = 2'h1;
	localparam ST_RESTART = 2'h2;
	localparam ST_LOCK    = 2'h3;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [1:0]       state_r;
	reg  [1:0]       state_nxt;
	reg  [CNT_W-1:0] win_cnt_r;
	reg              win_act_r;
	reg  [CNT_W-1:0] rst_cnt_r;
	reg  [CNT_W-1:0] chk_cnt_r;
	reg  [3:0]       relay_req_r;
	reg  [2:0]       save_cfg_r;
	reg              save_err_r;
	reg  [9:0]       defect_r;
	reg              first_r;
	reg              pend_save_r;
	reg              sfi_q_r;
	reg              key_q_r;
	reg  [1:0]       base_q_r;
	reg              ext_q_r;
	reg              links_valid_r;

	wire wr_en = psel & penable & pready & pwrite;
	wire key_press = reset_key & ~key_q_r;
	wire chk_tick = (chk_cnt_r == CHECK_CYCLES[CNT_W-1:0] - 1'b1);

	// ----------------------------------------
	// Interrupt sources
	// ----------------------------------------
	// relay supply low or scoped block input interrupt
	wire sfi = relay_supply_low | (block_in & block_scope_link);
	wire sfi_rise = sfi & ~sfi_q_r;
	wire event_hit = sfi_rise | proc_disturbance;

	// ----------------------------------------
	// Defect detection
	// ----------------------------------------
	// converter window, link and restart checks
	wire neg_bad = (neg_supply_channel < `NEG_LO) | (neg_supply_channel > `NEG_HI);
	wire adc_bad = (adc_check_channel < `ADC_LO) | (adc_check_channel > `ADC_HI);
	wire base_moved = chk_tick & links_valid_r & (base_range_link != base_q_r);
	wire ext_moved = chk_tick & links_valid_r & (ext_neutral_range_link != ext_q_r);
	wire restart_ok = (state_r == ST_RESTART) & (rst_cnt_r == RESTART_CYCLES[CNT_W-1:0] - 1'b1)
		& selftest_ok & ~relay_supply_low & ~logic_supply_low & ~sfi;

	reg        det_hit;
	reg  [9:0] det_code;
	always @* begin
		det_hit = 1'b1;
		det_code = `DEF_NONE;
		if (~checksum_ok) begin
			det_code = `DEF_EPROM;
		end else if (chk_tick & adc_bad) begin
			det_code = `DEF_ADC;
		end else if (chk_tick & neg_bad) begin
			det_code = `DEF_NEG_SUPPLY;
		end else if (base_moved) begin
			det_code = `DEF_BASE_LINK;
		end else if (ext_moved) begin
			det_code = `DEF_EXT_LINK;
		end else if (restart_ok) begin
			det_code = `DEF_RESTART;
		end else begin
			det_hit = 1'b0;
		end
	end

	// restart and 80 do not block
	wire def_blocks = (defect_r != `DEF_NONE) & (defect_r != `DEF_RESTART)
		& (defect_r != `DEF_NONBLOCK);
	wire save_bad = save_cfg_r[`SAVE_EF_ZERO_BIT] & save_cfg_r[`SAVE_EXT_N_BIT]
		& save_cfg_r[`SAVE_NPS_BIT];
	wire save_go = wr_en & (paddr == `ADDR_SAVE) & pwdata[`SAVE_GO_BIT];

	// ----------------------------------------
	// Restart state machine
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (event_hit & win_act_r) begin
					state_nxt = ST_LOCK;
				end else if (sfi_rise) begin
					state_nxt = ST_FAIL;
				end else if (proc_disturbance) begin
					state_nxt = ST_RESTART;
				end
			end
			ST_FAIL: begin
				if (win_act_r & proc_disturbance) begin
					state_nxt = ST_LOCK;
				end else if (~sfi) begin
					state_nxt = ST_RESTART;
				end
			end
			ST_RESTART: begin
				if (event_hit) begin
					state_nxt = ST_LOCK;
				end else if (restart_ok) begin
					state_nxt = ST_RUN;
				end
			end
			ST_LOCK: begin
				state_nxt = ST_LOCK;
			end
			default: begin
				state_nxt = ST_LOCK;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_RUN;
			win_act_r <= 1'b0;
			win_cnt_r <= {CNT_W{1'b0}};
			rst_cnt_r <= {CNT_W{1'b0}};
			hw_reset_r <= 1'b0;
			nv_save_r <= 1'b0;
			sfi_q_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sfi_q_r <= sfi;
			// save on each rising edge of sfi, except in lockout
			// A second interrupt that locks the relay must still save its state
			nv_save_r <= sfi_rise & (state_r != ST_LOCK);
			hw_reset_r <= (state_nxt == ST_RESTART) & (state_r != ST_RESTART);
			if (state_r == ST_RESTART) begin
				if (rst_cnt_r != RESTART_CYCLES[CNT_W-1:0] - 1'b1) begin
					rst_cnt_r <= rst_cnt_r + 1'b1;
				end
			end else begin
				rst_cnt_r <= {CNT_W{1'b0}};
			end
			if ((state_nxt == ST_RESTART) & (state_r != ST_RESTART)) begin
				win_act_r <= 1'b1;
				win_cnt_r <= {CNT_W{1'b0}};
			end else if (win_act_r & (state_r != ST_LOCK)) begin
				if (win_cnt_r == LOCKOUT_CYCLES[CNT_W-1:0] - 1'b1) begin
					win_act_r <= 1'b0;
					win_cnt_r <= {CNT_W{1'b0}};
				end else begin
					win_cnt_r <= win_cnt_r + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Periodic checks and defect register
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_cnt_r <= {CNT_W{1'b0}};
			base_q_r <= 2'h0;
			ext_q_r <= 1'b0;
			links_valid_r <= 1'b0;
			defect_r <= `DEF_NONE;
			first_r <= 1'b0;
			pend_save_r <= 1'b0;
			save_err_r <= 1'b0;
			settings_copy_r <= 1'b0;
			settings_save_r <= 1'b0;
			key_q_r <= 1'b0;
		end else begin
			key_q_r <= reset_key;
			chk_cnt_r <= chk_tick ? {CNT_W{1'b0}} : chk_cnt_r + 1'b1;
			if (chk_tick) begin
				base_q_r <= base_range_link;
				ext_q_r <= ext_neutral_range_link;
				links_valid_r <= 1'b1;
			end
			// copy settings groups on base range change
			settings_copy_r <= base_moved;
			settings_save_r <= save_go & ~save_bad;
			if (save_go) begin
				save_err_r <= save_bad;
			end else if (key_press) begin
				save_err_r <= 1'b0;
			end
			// Detection wins over a same-cycle acknowledge
			if (det_hit) begin
				defect_r <= det_code;
				first_r <= 1'b1;
				pend_save_r <= base_moved | ext_moved;
			end else if (wr_en & (paddr == `ADDR_DEFECT)) begin
				defect_r <= pwdata[9:0];
				first_r <= (pwdata[9:0] != `DEF_NONE);
			end else if (key_press) begin
				// link defects wait for a save
				first_r <= 1'b0;
				if (~pend_save_r) begin
					defect_r <= `DEF_NONE;
				end
			end else if (pend_save_r & ~first_r & save_go & ~save_bad) begin
				pend_save_r <= 1'b0;
				defect_r <= `DEF_NONE;
			end
		end
	end

	// ----------------------------------------
	// Relay, display and processor outputs
	// ----------------------------------------
	wire running = (state_r == ST_RUN) & ~logic_supply_low;
	wire [3:0] sel_block = {4{block_in & ~block_scope_link}} & per_relay_block_switches;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_out_r <= 4'h0;
			standby_relay_r <= 1'b0;
			standby_led_r <= 1'b0;
			display_on_r <= 1'b0;
			display_flash_r <= 1'b0;
			mode_code_r <= `DEF_NONE;
			restart_ind_r <= 1'b0;
			proc_block_r <= 1'b1;
			key_accept_r <= 1'b0;
		end else begin
			// all relays drop outside normal run
			relay_out_r <= (running & ~def_blocks) ? (relay_req_r & ~sel_block) : 4'h0;
			standby_relay_r <= running & ~def_blocks;
			standby_led_r <= running & ~def_blocks;
			display_on_r <= running;
			display_flash_r <= running & ((defect_r != `DEF_NONE) | save_err_r);
			mode_code_r <= save_err_r ? `MODE_SAVE_ERROR : defect_r;
			restart_ind_r <= running & (defect_r == `DEF_RESTART);
			// processor blocked on low logic supply
			proc_block_r <= logic_supply_low | (state_r != ST_RUN);
			// only reset key during first indication
			key_accept_r <= other_key & running & ~first_r;
		end
	end

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			relay_req_r <= `RELAY_REQ_RST;
			save_cfg_r <= 3'h0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				prdata <= 32'h0;
				case (paddr)
					`ADDR_RELAY_CTRL: prdata <= {28'h0, relay_req_r};
					`ADDR_STATUS: prdata <= {24'h0, logic_supply_low, sfi, pend_save_r, save_err_r,
						first_r, win_act_r, state_r};
					`ADDR_DEFECT: prdata <= {22'h0, defect_r};
					`ADDR_SAVE: prdata <= {22'h0, save_err_r, 6'h0, save_cfg_r};
					default: pslverr <= 1'b1;
				endcase
			end
			if (wr_en & (paddr == `ADDR_RELAY_CTRL)) begin
				relay_req_r <= pwdata[3:0];
			end
			if (wr_en & (paddr == `ADDR_SAVE)) begin
				save_cfg_r <= pwdata[2:0];
			end
		end
	end

endmodule // supervisor_restart_blocking

// ---- supervisor_far_side.sv ----
// Far-side model: supply monitors, blocking contact, sensors
module supervisor_far_side (
	input  wire       pclk,
	input  wire       rail_drop,
	input  wire       block_cmd,
	input  wire       glitch_cmd,
	input  wire       csum_bad,
	input  wire [1:0] chan_bad_cmd,
	input  wire       test_fail,
	output wire       relay_supply_low,
	output wire       block_in,
	output reg        proc_disturbance = 1'b0,
	output wire       checksum_ok,
	output wire       selftest_ok,
	output wire [7:0] neg_supply_channel,
	output wire [7:0] adc_check_channel
);
	reg glitch_q = 1'b0;
	assign relay_supply_low = rail_drop;
	assign block_in = block_cmd;
	assign checksum_ok = !csum_bad;
	assign selftest_ok = !test_fail;
	// Mid-window samples so only commanded faults show
	assign neg_supply_channel = chan_bad_cmd[1] ? 8'h00 : 8'h80;
	assign adc_check_channel = chan_bad_cmd[0] ? 8'hff : 8'h80;
	always @(posedge pclk) begin
		glitch_q <= glitch_cmd;
		proc_disturbance <= glitch_cmd & ~glitch_q;
	end
endmodule // supervisor_far_side

// ---- supervisor_restart_blocking_checker.sv ----
// Assertion checker for the supervision controller
`include "supervisor_consts.vh"
module supervisor_checker #(
	parameter LOCKOUT_CYCLES = 200,
	parameter RESTART_CYCLES = 20
) (
	input wire       pclk,
	input wire       presetn,
	input wire       logic_supply_low,
	input wire       relay_supply_low,
	input wire       proc_disturbance,
	input wire       block_in,
	input wire       block_scope_link,
	input wire [3:0] per_relay_block_switches,
	input wire [3:0] relay_out_r,
	input wire       standby_relay_r,
	input wire       standby_led_r,
	input wire       display_on_r,
	input wire       display_flash_r,
	input wire [9:0] mode_code_r,
	input wire       restart_ind_r,
	input wire       proc_block_r,
	input wire       hw_reset_r,
	input wire       nv_save_r
);
	int win_r;
	int since_r;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Own copy of the lockout window; a one-cycle skew is tolerated below
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_r <= 0;
			since_r <= 0;
		end else begin
			win_r <= hw_reset_r ? LOCKOUT_CYCLES - 1 : (win_r > 0 ? win_r - 1 : 0);
			since_r <= hw_reset_r ? 0 : since_r + 1;
		end
	end
	// ----------
	// Assertions
	// ----------
	chk_logic_block: assert property (logic_supply_low |=> proc_block_r)
		else $error("processor free while logic supply low");
	chk_fail_outputs: assert property ($rose(relay_supply_low) |-> ##3
		(relay_out_r == 4'h0 && !standby_relay_r && !standby_led_r && !display_on_r))
		else $error("outputs not dropped on supply fail");
	chk_fail_save: assert property ($rose(relay_supply_low) && standby_relay_r |-> ##[1:3] nv_save_r)
		else $error("no store pulse on supply fail");
	chk_single_reset: assert property (hw_reset_r |-> win_r == 0)
		else $error("second reset inside lockout window");
	chk_lock_second: assert property ((proc_disturbance || $rose(relay_supply_low) ||
		$rose(block_in && block_scope_link)) && win_r > 1 |-> ##2 proc_block_r [*8])
		else $error("no permanent block on repeat event");
	chk_rearm_reset: assert property (proc_disturbance && win_r == 0 &&
		standby_relay_r && !proc_block_r |=> hw_reset_r)
		else $error("reset not re-armed after window");
	chk_flash_code: assert property ($rose(restart_ind_r) |->
		mode_code_r == `DEF_RESTART && display_flash_r)
		else $error("restart indication without code 99");
	chk_restart_time: assert property ($rose(restart_ind_r) |-> since_r >= RESTART_CYCLES - 2)
		else $error("restart finished too early");
	chk_per_relay: assert property (!block_scope_link && block_in |=>
		(relay_out_r & $past(per_relay_block_switches)) == 4'h0)
		else $error("selected relay not held reset");
	chk_defect_standby: assert property (mode_code_r == `DEF_EPROM &&
		$past(mode_code_r) == `DEF_EPROM |-> !standby_relay_r)
		else $error("standby kept during defect");
	cover property (hw_reset_r);
	cover property (proc_block_r && win_r > 1);
	cover property (restart_ind_r && display_flash_r);
endmodule // supervisor_checker

bind supervisor_restart_blocking supervisor_checker #(
	.LOCKOUT_CYCLES(LOCKOUT_CYCLES),
	.RESTART_CYCLES(RESTART_CYCLES)
) u_supervisor_checker (.*);

// ---- tb_supervisor_restart_blocking.sv ----
// Self-checking bench for the supervision controller
`include "supervisor_consts.vh"
module tb_supervisor_restart_blocking;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LOCK_N = 200;
	localparam int REST_N = 20;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic [7:0]  paddr, neg_supply_channel, adc_check_channel;
	logic [31:0] pwdata, prdata, rd;
	logic        logic_supply_low, relay_supply_low, proc_disturbance, block_in;
	logic        block_scope_link, checksum_ok, selftest_ok, reset_key, other_key;
	logic        ext_neutral_range_link, rail_drop, block_cmd, glitch_cmd, csum_bad;
	logic [1:0]  base_range_link;
	logic [3:0]  per_relay_block_switches, relay_out_r;
	logic        standby_relay_r, standby_led_r, display_on_r, display_flash_r;
	logic        restart_ind_r, proc_block_r, hw_reset_r, nv_save_r;
	logic        settings_copy_r, settings_save_r, key_accept_r;
	logic [9:0]  mode_code_r;
	logic [1:0]  chan_bad_cmd;
	logic        test_fail;
	int          err_count, samples_checked, hw_n, nv_n, save_n, copy_n;

	supervisor_restart_blocking #(
		.LOCKOUT_CYCLES(LOCK_N),
		.RESTART_CYCLES(REST_N),
		.CHECK_CYCLES(8)
	) u_supervisor_restart_blocking (.*);
	supervisor_far_side u_supervisor_far_side (.*);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Pulses are counted so no single cycle can be missed
	always @(posedge pclk) begin
		hw_n += (hw_reset_r === 1'b1);
		nv_n += (nv_save_r === 1'b1);
		save_n += (settings_save_r === 1'b1);
		copy_n += (settings_copy_r === 1'b1);
	end
	// ------------------
	// Shared tasks
	// ------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		serr = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		cyc(3);
	endtask
	task automatic press();
		reset_key <= 1'b1;
		cyc(2);
		reset_key <= 1'b0;
		cyc(3);
	endtask
	task automatic wait_restart();
		repeat (REST_N * 4) if (restart_ind_r !== 1'b1) @(posedge pclk);
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ------------------
	// Scenarios
	// ------------------
	task automatic t_regs();
		apb(1'b0, `ADDR_DEFECT, 32'h0);
		chk(rd, 32'h0);
		chk(mode_code_r, `DEF_NONE);
		apb(1'b1, `ADDR_RELAY_CTRL, 32'ha);
		apb(1'b1, `ADDR_STATUS, 32'hff);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(serr, 1'b1);
		apb(1'b0, `ADDR_RELAY_CTRL, 32'h0);
		chk(rd, 32'ha);
		chk(relay_out_r, 4'ha);
		$display("done regs");
	endtask
	task automatic t_per();
		apb(1'b1, `ADDR_RELAY_CTRL, 32'hf);
		per_relay_block_switches <= 4'h5;
		block_cmd <= 1'b1;
		cyc(3);
		chk(relay_out_r, 4'ha);
		chk({standby_relay_r, proc_block_r}, 2'b10);
		block_cmd <= 1'b0;
		cyc(3);
		chk(relay_out_r, 4'hf);
		$display("done per-relay");
	endtask
	task automatic t_def();
		csum_bad <= 1'b1;
		cyc(4);
		chk(mode_code_r, `DEF_EPROM);
		chk({standby_relay_r, relay_out_r}, 5'h0);
		other_key <= 1'b1;
		cyc(3);
		chk(key_accept_r, 1'b0);
		{other_key, csum_bad} <= 2'b00;
		press();
		chk(mode_code_r, `DEF_NONE);
		other_key <= 1'b1;
		cyc(3);
		chk(key_accept_r, 1'b1);
		other_key <= 1'b0;
		chan_bad_cmd <= 2'b01;
		cyc(12);
		chk(mode_code_r, `DEF_ADC);
		chan_bad_cmd <= 2'b10;
		cyc(12);
		chk(mode_code_r, `DEF_NEG_SUPPLY);
		chan_bad_cmd <= 2'b00;
		press();
		chk(mode_code_r, `DEF_NONE);
		logic_supply_low <= 1'b1;
		cyc(3);
		chk(proc_block_r, 1'b1);
		logic_supply_low <= 1'b0;
		cyc(3);
		chk(proc_block_r, 1'b0);
		$display("done defect");
	endtask
	task automatic t_fail();
		rail_drop <= 1'b1;
		cyc(4);
		chk({relay_out_r, standby_relay_r}, 5'h0);
		chk({standby_led_r, display_on_r}, 2'b00);
		chk(nv_n, 1);
		rail_drop <= 1'b0;
		wait_restart();
		chk(hw_n, 1);
		chk({mode_code_r, display_flash_r}, {`DEF_RESTART, 1'b1});
		chk(standby_relay_r, 1'b1);
		press();
		chk({mode_code_r, restart_ind_r}, 11'h0);
		$display("done supply fail");
	endtask
	task automatic t_lock();
		cyc(LOCK_N + 20);
		glitch_cmd <= 1'b1;
		cyc(4);
		glitch_cmd <= 1'b0;
		chk({hw_n, proc_block_r}, {32'd2, 1'b1});
		wait_restart();
		press();
		{block_scope_link, block_cmd} <= 2'b11;
		cyc(5);
		chk({relay_out_r, standby_relay_r}, 5'h0);
		block_cmd <= 1'b0;
		cyc(REST_N * 3);
		chk({hw_n, proc_block_r}, {32'd2, 1'b1});
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(rd[1:0], 2'd3);
		block_scope_link <= 1'b0;
		$display("done lockout");
	endtask
	task automatic t_save();
		save_n = 0;
		apb(1'b1, `ADDR_SAVE, 32'h7);
		apb(1'b1, `ADDR_SAVE, 32'h107);
		apb(1'b0, `ADDR_SAVE, 32'h0);
		chk({rd[9], save_n}, {1'b1, 32'd0});
		chk(mode_code_r, `MODE_SAVE_ERROR);
		apb(1'b1, `ADDR_SAVE, 32'h0);
		apb(1'b1, `ADDR_SAVE, 32'h100);
		cyc(2);
		chk(save_n, 1);
		$display("done save");
	endtask
	task automatic t_link();
		base_range_link <= 2'h1;
		cyc(12);
		chk(mode_code_r, `DEF_BASE_LINK);
		chk(copy_n, 1);
		press();
		chk(mode_code_r, `DEF_BASE_LINK);
		apb(1'b1, `ADDR_SAVE, 32'h100);
		cyc(2);
		chk(mode_code_r, `DEF_NONE);
		ext_neutral_range_link <= 1'b1;
		cyc(12);
		chk(mode_code_r, `DEF_EXT_LINK);
		chk(copy_n, 1);
		press();
		apb(1'b1, `ADDR_SAVE, 32'h100);
		cyc(2);
		chk(mode_code_r, `DEF_NONE);
		$display("done links");
	endtask
	task automatic t_self();
		test_fail <= 1'b1;
		glitch_cmd <= 1'b1;
		cyc(2);
		glitch_cmd <= 1'b0;
		cyc(REST_N + 10);
		chk({restart_ind_r, proc_block_r}, 2'b01);
		test_fail <= 1'b0;
		wait_restart();
		chk({restart_ind_r, standby_relay_r}, 2'b11);
		$display("done self-test");
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{logic_supply_low, block_scope_link, reset_key, other_key} = '0;
		{ext_neutral_range_link, base_range_link, per_relay_block_switches} = '0;
		{rail_drop, block_cmd, glitch_cmd, csum_bad} = '0;
		{chan_bad_cmd, test_fail} = '0;
		rst();
		t_regs();
		t_per();
		t_def();
		t_link();
		t_fail();
		t_lock();
		rst();
		t_save();
		t_self();
		print_verdict();
	end
	initial begin
		repeat (6000) @(posedge pclk);
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule // tb_supervisor_restart_blocking
